// >>> src/agu_cfg.svh
`ifndef AGU_CFG_SVH
`define AGU_CFG_SVH

// Register byte offsets
`define AGU_OFS_MODE_CTRL 8'h00
`define AGU_OFS_BREV_CTRL 8'h04
`define AGU_OFS_TABLE_PAGE 8'h08
`define AGU_OFS_VIS_PAGE 8'h0C
`define AGU_OFS_X_START 8'h10
`define AGU_OFS_X_END 8'h14
`define AGU_OFS_Y_START 8'h18
`define AGU_OFS_Y_END 8'h1C
`define AGU_OFS_WINDOW_CTRL 8'h20
`define AGU_OFS_STATUS 8'h24

// Address mode control fields
`define AGU_XSEL_LSB 0
`define AGU_YSEL_LSB 4
`define AGU_BSEL_LSB 8
`define AGU_YEN_BIT 14
`define AGU_XEN_BIT 15
`define AGU_SEL_OFF 4'hF

// Bit-reverse control and table page fields
`define AGU_BREV_EN_BIT 15
`define AGU_CFG_PAGE_BIT 7

// Reset values
`define AGU_RST_MODE_CTRL 16'h0FFF
`define AGU_RST_BREV_CTRL 16'h0000
`define AGU_RST_PAGE 8'h00
`define AGU_RST_BOUND 16'h0000
`define AGU_RST_WINDOW 1'b0

`endif

// >>> src/agu_pkg.sv
`default_nettype none

package agu_pkg;

  typedef enum logic [1:0] {AGU_X_READ, AGU_X_WRITE, AGU_Y_SPACE} agu_space_t;

  typedef enum logic [2:0] {
    AGU_INDIRECT, AGU_POST_INC, AGU_POST_DEC, AGU_PRE_INC, AGU_PRE_DEC, AGU_OFFSET
  } agu_mode_t;

  typedef enum logic {AGU_TABLE, AGU_WINDOW} agu_pkind_t;

  typedef struct packed {
    logic valid;
    agu_space_t space;
    agu_mode_t mode;
    logic byte_acc;
    logic [3:0] ptr_sel;
    logic [15:0] ptr_val;
    logic [15:0] offset;
  } agu_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] ea;
    logic wb_valid;
    logic [3:0] wb_sel;
    logic [15:0] wb_val;
    logic bit_reversed;
    logic wrapped;
  } agu_rsp_t;

  typedef struct packed {
    logic valid;
    agu_pkind_t kind;
    logic write;
    logic [15:0] ea;
  } agu_preq_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [23:0] addr;
    logic config_space;
    logic low_word_only;
    logic refused;
  } agu_prsp_t;

endpackage : agu_pkg

`default_nettype wire

// >>> src/agu_top.sv
// Operation
// - Incrementing buffers test the upper bound, decrementing ones the lower bound.
// - Bounds use greater or less comparison so overshooting steps still wrap.
// - Corrected address goes back to the pointer only for pre/post modify.
// - Register plus offset is corrected but the pointer stays unchanged.
// - Bit reversal only on the X write generator, never on reads.
// - Only the modifier is bit reversed; pointer stays in normal order.
// - Bit reversal needs select not 15, enable set, pre/post increment.
// - The pivot modifier is a 15-bit field, usually half the buffer.
// - Reversed addresses are word addresses: LSb zero, pivot scaled to bytes.
// - Byte writes or other modes get the ordinary address despite enable.
// - Reversed mode adds pointer and pivot, ignoring the mode's increment.
// - Reversal beats circular on X write; X read keeps circular correction.
// - Sixteen-entry sequence mirrors the four index bits.
// - Program words are 24 bits, data words 16 bits, alignment kept.
// - Table address is table page above the 16-bit effective address.
// - Table page top bit picks user (0) or configuration (1) space.
// - Window address is visibility page plus low 15 bits, bit 23 zero.
// - Data bit 15 is dropped; program bit 15 is visibility page bit 0.
// - Window accesses are read only and return the low program word.
// - Table accesses need no alignment and may read configuration space.
// - X circular select is bits 3:0, enable bit 15, select not 15.
// - Y circular select is bits 7:4, enable bit 14, select not 15.
// - Bounds come from 16-bit start/end registers; Y circular corrected addresses are word aligned.
//
// The APB register port and the register addresses were chosen for this implementation.
`include "agu_cfg.svh"
`default_nettype none

module agu_top
  import agu_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // APB register port
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Data address request and answer
  input wire agu_req_t agu_req_in,
  output agu_rsp_t agu_rsp_out,
  // Program address request and answer
  input wire agu_preq_t prog_req_in,
  output agu_prsp_t prog_rsp_out
);

  function automatic logic [15:0] agu_rev16(input logic [15:0] a);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++)
      r[i] = a[15 - i];
    return r;
  endfunction

  // Upper bound for rising, lower for falling; returns {wrapped, addr}
  function automatic logic [16:0] agu_wrap(input logic [15:0] a, input logic up,
                                           input logic [15:0] lo, input logic [15:0] hi);
    logic [15:0] len;
    len = hi - lo + 16'h0001;
    if (up && (a > hi))
      return {1'b1, a - len};
    else if (!up && (a < lo))
      return {1'b1, a + len};
    else
      return {1'b0, a};
  endfunction

  function automatic logic agu_sel_on(input logic en, input logic [3:0] sel,
                                      input logic [3:0] ptr);
    return en && (sel != `AGU_SEL_OFF) && (ptr == sel);
  endfunction

  logic [15:0] mode_ctrl_reg;
  logic [15:0] brev_ctrl_reg;
  logic [7:0] table_page_reg;
  logic [7:0] vis_page_reg;
  logic [15:0] x_start_reg;
  logic [15:0] x_end_reg;
  logic [15:0] y_start_reg;
  logic [15:0] y_end_reg;
  logic window_en_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  agu_rsp_t rsp_reg;
  agu_rsp_t rsp_next;
  agu_prsp_t prsp_reg;
  agu_prsp_t prsp_next;

  // APB decode
  wire access_w = psel_in && penable_in;
  wire take_w = access_w && !pready_reg;
  wire commit_w = access_w && pready_reg && pwrite_in && !pslverr_reg;
  wire hit_mode_w = paddr_in == `AGU_OFS_MODE_CTRL;
  wire hit_brev_w = paddr_in == `AGU_OFS_BREV_CTRL;
  wire hit_tpage_w = paddr_in == `AGU_OFS_TABLE_PAGE;
  wire hit_vpage_w = paddr_in == `AGU_OFS_VIS_PAGE;
  wire hit_xs_w = paddr_in == `AGU_OFS_X_START;
  wire hit_xe_w = paddr_in == `AGU_OFS_X_END;
  wire hit_ys_w = paddr_in == `AGU_OFS_Y_START;
  wire hit_ye_w = paddr_in == `AGU_OFS_Y_END;
  wire hit_win_w = paddr_in == `AGU_OFS_WINDOW_CTRL;
  wire hit_stat_w = paddr_in == `AGU_OFS_STATUS;
  wire mapped_w = hit_mode_w || hit_brev_w || hit_tpage_w || hit_vpage_w || hit_xs_w
                  || hit_xe_w || hit_ys_w || hit_ye_w || hit_win_w || hit_stat_w;
  // Status is read only
  wire bad_w = !mapped_w || (pwrite_in && hit_stat_w);
  wire [31:0] status_w = {rsp_reg.bit_reversed, rsp_reg.wrapped, 14'h0000, rsp_reg.ea};
  wire [31:0] rdata_w =
    hit_mode_w ? {16'h0000, mode_ctrl_reg} :
    hit_brev_w ? {16'h0000, brev_ctrl_reg} :
    hit_tpage_w ? {24'h000000, table_page_reg} :
    hit_vpage_w ? {24'h000000, vis_page_reg} :
    hit_xs_w ? {16'h0000, x_start_reg} :
    hit_xe_w ? {16'h0000, x_end_reg} :
    hit_ys_w ? {16'h0000, y_start_reg} :
    hit_ye_w ? {16'h0000, y_end_reg} :
    hit_win_w ? {31'h00000000, window_en_reg} :
    hit_stat_w ? status_w : 32'h00000000;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      pready_reg <= take_w;
      pslverr_reg <= take_w && bad_w;
      if (take_w)
        prdata_reg <= (pwrite_in || bad_w) ? 32'h00000000 : rdata_w;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      mode_ctrl_reg <= `AGU_RST_MODE_CTRL;
      brev_ctrl_reg <= `AGU_RST_BREV_CTRL;
      table_page_reg <= `AGU_RST_PAGE;
      vis_page_reg <= `AGU_RST_PAGE;
      x_start_reg <= `AGU_RST_BOUND;
      x_end_reg <= `AGU_RST_BOUND;
      y_start_reg <= `AGU_RST_BOUND;
      y_end_reg <= `AGU_RST_BOUND;
      window_en_reg <= `AGU_RST_WINDOW;
    end
    else if (commit_w)
    begin
      if (hit_mode_w) mode_ctrl_reg <= pwdata_in[15:0];
      if (hit_brev_w) brev_ctrl_reg <= pwdata_in[15:0];
      if (hit_tpage_w) table_page_reg <= pwdata_in[7:0];
      if (hit_vpage_w) vis_page_reg <= pwdata_in[7:0];
      if (hit_xs_w) x_start_reg <= pwdata_in[15:0];
      if (hit_xe_w) x_end_reg <= pwdata_in[15:0];
      if (hit_ys_w) y_start_reg <= pwdata_in[15:0];
      if (hit_ye_w) y_end_reg <= pwdata_in[15:0];
      if (hit_win_w) window_en_reg <= pwdata_in[0];
    end
  end

  // Control fields
  wire [3:0] x_sel_w = mode_ctrl_reg[`AGU_XSEL_LSB +: 4];
  wire [3:0] y_sel_w = mode_ctrl_reg[`AGU_YSEL_LSB +: 4];
  wire [3:0] b_sel_w = mode_ctrl_reg[`AGU_BSEL_LSB +: 4];
  wire x_en_w = mode_ctrl_reg[`AGU_XEN_BIT];
  wire y_en_w = mode_ctrl_reg[`AGU_YEN_BIT];
  wire brev_en_w = brev_ctrl_reg[`AGU_BREV_EN_BIT];
  wire [14:0] pivot_w = brev_ctrl_reg[14:0];

  // Data address path
  agu_req_t rq;
  assign rq = agu_req_in;
  wire is_y_w = rq.space == AGU_Y_SPACE;
  wire is_inc_w = (rq.mode == AGU_PRE_INC) || (rq.mode == AGU_POST_INC);
  wire is_dec_w = (rq.mode == AGU_PRE_DEC) || (rq.mode == AGU_POST_DEC);
  wire is_pre_w = (rq.mode == AGU_PRE_INC) || (rq.mode == AGU_PRE_DEC);
  wire is_modify_w = is_inc_w || is_dec_w;
  wire is_offset_w = rq.mode == AGU_OFFSET;
  wire x_circ_w = agu_sel_on(x_en_w, x_sel_w, rq.ptr_sel);
  wire y_circ_w = agu_sel_on(y_en_w, y_sel_w, rq.ptr_sel);
  wire brev_w = (rq.space == AGU_X_WRITE) && !rq.byte_acc && is_inc_w
                && agu_sel_on(brev_en_w, b_sel_w, rq.ptr_sel);
  wire circ_w = is_y_w ? y_circ_w : (x_circ_w && !brev_w);
  wire up_w = is_inc_w || (is_offset_w && !rq.offset[15]);
  wire [15:0] moved_w = is_dec_w ? rq.ptr_val - rq.offset :
                        (is_modify_w || is_offset_w) ? rq.ptr_val + rq.offset : rq.ptr_val;
  wire [15:0] lo_w = is_y_w ? y_start_reg : x_start_reg;
  wire [15:0] hi_w = is_y_w ? y_end_reg : x_end_reg;
  wire [16:0] wrap_w = agu_wrap(moved_w, up_w, lo_w, hi_w);
  wire apply_wrap_w = circ_w && (is_modify_w || is_offset_w);
  wire [15:0] corr_raw_w = apply_wrap_w ? wrap_w[15:0] : moved_w;
  wire [15:0] corr_w = is_y_w && circ_w ? {corr_raw_w[15:1], 1'b0} : corr_raw_w;
  // Reverse-carry add of pointer and byte-scaled pivot; increment ignored
  wire [15:0] pivot_bytes_w = {pivot_w, 1'b0};
  wire [15:0] rsum_w = agu_rev16(rq.ptr_val) + agu_rev16(pivot_bytes_w);
  wire [15:0] brev_sum_w = agu_rev16(rsum_w) & 16'hFFFE;
  wire [15:0] new_ptr_w = brev_w ? brev_sum_w : corr_w;
  wire [15:0] post_ea_w = brev_w ? (rq.ptr_val & 16'hFFFE) : rq.ptr_val;
  wire [15:0] ea_w = (is_pre_w || is_offset_w) ? new_ptr_w : post_ea_w;

  always_comb
  begin
    rsp_next = '0;
    rsp_next.valid = rq.valid;
    rsp_next.ea = ea_w;
    rsp_next.wb_valid = rq.valid && is_modify_w;
    rsp_next.wb_sel = rq.ptr_sel;
    rsp_next.wb_val = new_ptr_w;
    rsp_next.bit_reversed = rq.valid && brev_w;
    rsp_next.wrapped = rq.valid && apply_wrap_w && wrap_w[16];
  end

  // Program address path
  agu_preq_t pq;
  assign pq = prog_req_in;
  wire is_table_w = pq.kind == AGU_TABLE;
  // Table accesses suspend the window
  wire win_hit_w = !is_table_w && window_en_reg && pq.ea[15];
  wire [23:0] table_addr_w = {table_page_reg, pq.ea};
  wire [23:0] win_addr_w = {1'b0, vis_page_reg, pq.ea[14:0]};

  always_comb
  begin
    prsp_next = '0;
    prsp_next.valid = pq.valid;
    prsp_next.hit = pq.valid && (is_table_w || win_hit_w);
    prsp_next.addr = is_table_w ? table_addr_w : (win_hit_w ? win_addr_w : 24'h000000);
    prsp_next.config_space = pq.valid && is_table_w && table_page_reg[`AGU_CFG_PAGE_BIT];
    prsp_next.low_word_only = pq.valid && win_hit_w;
    prsp_next.refused = pq.valid && win_hit_w && pq.write;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rsp_reg <= '0;
      prsp_reg <= '0;
    end
    else
    begin
      rsp_reg <= rsp_next;
      prsp_reg <= prsp_next;
    end
  end

  assign prdata_out = prdata_reg;
  assign pready_out = pready_reg;
  assign pslverr_out = pslverr_reg;
  assign agu_rsp_out = rsp_reg;
  assign prog_rsp_out = prsp_reg;

  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  agu_req_t rq_q;
  agu_preq_t pq_q;
  logic [15:0] mode_q;
  logic [15:0] brev_q;
  logic [7:0] tpage_q;
  logic [7:0] vpage_q;
  logic win_q;
  always_ff @(posedge clk_in)
  begin
    rq_q <= agu_req_in;
    pq_q <= prog_req_in;
    mode_q <= mode_ctrl_reg;
    brev_q <= brev_ctrl_reg;
    tpage_q <= table_page_reg;
    vpage_q <= vis_page_reg;
    win_q <= window_en_reg;
  end

  wire q_brev_w = (rq_q.space == AGU_X_WRITE) && !rq_q.byte_acc
                  && ((rq_q.mode == AGU_PRE_INC) || (rq_q.mode == AGU_POST_INC))
                  && brev_q[15] && (mode_q[11:8] != 4'hF) && (rq_q.ptr_sel == mode_q[11:8]);

  wb_only_modify_a: assert property (
    rsp_reg.wb_valid |-> rq_q.valid && (rq_q.mode != AGU_OFFSET)
                         && (rq_q.mode != AGU_INDIRECT))
    else $error("pointer write-back for a mode without modify");

  offset_no_wb_a: assert property (
    agu_req_in.valid && (agu_req_in.mode == AGU_OFFSET) |=> !rsp_reg.wb_valid)
    else $error("offset mode changed the pointer");

  brev_read_a: assert property (
    rsp_reg.bit_reversed |-> rq_q.space == AGU_X_WRITE)
    else $error("bit reversal on a read or Y access");

  brev_cond_a: assert property (
    rsp_reg.bit_reversed == (rq_q.valid && q_brev_w))
    else $error("bit reversal not tied to its enable conditions");

  brev_lsb_a: assert property (
    rsp_reg.bit_reversed |-> !rsp_reg.wb_val[0] && !rsp_reg.ea[0])
    else $error("reversed address with LSb set");

  brev_step_a: assert property (
    rsp_reg.bit_reversed && (brev_q[14:0] == 15'h0008) && (rq_q.ptr_val[4:0] == 5'h00)
    |-> rsp_reg.wb_val == rq_q.ptr_val + 16'h0010)
    else $error("reversed index 1 did not map to 8");

  no_wrap_brev_a: assert property (
    rsp_reg.bit_reversed |-> !rsp_reg.wrapped)
    else $error("circular correction on a reversed write");

  up_wrap_a: assert property (
    rsp_reg.wrapped && (rq_q.mode == AGU_POST_INC) |-> rsp_reg.wb_val < rq_q.ptr_val + rq_q.offset)
    else $error("incrementing wrap did not move down");

  down_wrap_a: assert property (
    rsp_reg.wrapped && (rq_q.mode == AGU_POST_DEC) |-> rsp_reg.wb_val > rq_q.ptr_val - rq_q.offset)
    else $error("decrementing wrap did not move up");

  x_circ_sel_a: assert property (
    rsp_reg.wrapped && (rq_q.space != AGU_Y_SPACE)
    |-> mode_q[15] && (mode_q[3:0] != 4'hF) && (rq_q.ptr_sel == mode_q[3:0]))
    else $error("X wrap without its enable and select");

  y_word_a: assert property (
    rsp_reg.wb_valid && (rq_q.space == AGU_Y_SPACE) && mode_q[14] && (mode_q[7:4] != 4'hF)
    && (rq_q.ptr_sel == mode_q[7:4]) |-> !rsp_reg.wb_val[0])
    else $error("Y circular pointer with LSb set");

  table_addr_a: assert property (
    prsp_reg.valid && (pq_q.kind == AGU_TABLE) |-> prsp_reg.addr == {tpage_q, pq_q.ea})
    else $error("table address not page over EA");

  cfg_space_a: assert property (
    prsp_reg.valid && (pq_q.kind == AGU_TABLE) |-> prsp_reg.config_space == tpage_q[7])
    else $error("configuration space flag wrong");

  win_addr_a: assert property (
    prsp_reg.low_word_only |-> prsp_reg.addr == {1'b0, vpage_q, pq_q.ea[14:0]})
    else $error("window address wrong");

  win_bit15_a: assert property (
    prsp_reg.low_word_only |-> win_q && pq_q.ea[15] && (prsp_reg.addr[15] == vpage_q[0])
                               && !prsp_reg.addr[23])
    else $error("window bit 15 or bit 23 wrong");

  table_no_window_a: assert property (
    prsp_reg.valid && (pq_q.kind == AGU_TABLE)
    |-> prsp_reg.hit && !prsp_reg.refused && !prsp_reg.low_word_only)
    else $error("table access refused or windowed");

  win_write_a: assert property (
    prog_req_in.valid && (prog_req_in.kind == AGU_WINDOW) && prog_req_in.write
    && prog_req_in.ea[15] && window_en_reg |=> prsp_reg.refused && !prsp_reg.config_space)
    else $error("window write not refused");

  apb_answer_a: assert property (
    psel_in && penable_in && !pready_out |=> pready_out)
    else $error("APB access not answered in one wait state");

  cover_brev_c: cover property (rsp_reg.bit_reversed);
  cover_wrap_c: cover property (rsp_reg.wrapped && rsp_reg.wb_valid);
  cover_win_c: cover property (prsp_reg.low_word_only && !prsp_reg.refused);
  cover_cfg_c: cover property (prsp_reg.config_space);
  cover_pre_rev_c: cover property (rsp_reg.bit_reversed && (rq_q.mode == AGU_PRE_INC));

endmodule // agu_top

`default_nettype wire

// >>> tb/agu_cpu_model.sv
`default_nettype none

module agu_cpu_model
  import agu_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Command from bench, answer from the unit
  input wire agu_req_t cmd_in,
  input wire agu_rsp_t rsp_in,
  // Pointer preload from bench
  input wire logic load_in,
  input wire logic [3:0] load_sel_in,
  input wire logic [15:0] load_val_in,
  // Request towards the unit
  output agu_req_t req_out
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] ptr_reg [16];

  // Pointer value comes from the model's own pointer file
  always_comb
  begin
    req_out = cmd_in;
    req_out.ptr_val = ptr_reg[cmd_in.ptr_sel];
  end

  // Only reset, a bench preload or a returned write-back may change a pointer
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < 16; i++)
        ptr_reg[i] <= 16'h0000;
    end
    else if (load_in)
    begin
      ptr_reg[load_sel_in] <= load_val_in;
    end
    else if (rsp_in.valid && rsp_in.wb_valid)
    begin
      ptr_reg[rsp_in.wb_sel] <= rsp_in.wb_val;
    end
  end
endmodule // agu_cpu_model

`default_nettype wire

// >>> tb/tb.sv
`include "agu_cfg.svh"
`default_nettype none

module tb
  import agu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_in, rst_in, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic ld;
  logic [3:0] ld_sel;
  logic [15:0] ld_val;
  logic [31:0] pwdata, prdata, rdat;
  agu_req_t cmd, req;
  agu_rsp_t rsp_w, rsp;
  agu_preq_t preq_d;
  agu_prsp_t prsp_w, prsp;
  int err_count = 0;
  int cmp_count = 0;

  agu_top i_agu_top (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .agu_req_in(req), .agu_rsp_out(rsp_w),
    .prog_req_in(preq_d), .prog_rsp_out(prsp_w));
  agu_cpu_model i_agu_cpu_model (.clk_in(clk_in), .rst_in(rst_in), .cmd_in(cmd),
    .rsp_in(rsp_w), .load_in(ld), .load_sel_in(ld_sel), .load_val_in(ld_val), .req_out(req));

  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    chk("pready", 1, pready);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic setp(input logic [3:0] p, input logic [15:0] v);
    @(posedge clk_in);
    ld <= 1'b1;
    ld_sel <= p;
    ld_val <= v;
    @(posedge clk_in);
    ld <= 1'b0;
  endtask

  task automatic dreq(input agu_space_t s, input agu_mode_t m, input logic b,
                      input logic [3:0] p, input logic [15:0] o);
    @(posedge clk_in);
    cmd <= '{valid: 1'b1, space: s, mode: m, byte_acc: b, ptr_sel: p,
             ptr_val: 16'h0000, offset: o};
    @(posedge clk_in);
    cmd.valid <= 1'b0;
    #1;
    rsp = rsp_w;
    chk("rsp valid", 1, rsp.valid);
  endtask

  task automatic pget(input agu_pkind_t k, input logic w, input logic [15:0] ea);
    @(posedge clk_in);
    preq_d <= '{valid: 1'b1, kind: k, write: w, ea: ea};
    @(posedge clk_in);
    preq_d.valid <= 1'b0;
    #1;
    prsp = prsp_w;
    chk("prsp valid", 1, prsp.valid);
  endtask

  function automatic logic [3:0] rev4(input logic [3:0] v);
    return {v[0], v[1], v[2], v[3]};
  endfunction

  task automatic t_regs();
    apb(0, `AGU_OFS_MODE_CTRL, 32'h0);
    chk("mode ctrl reset", 32'h0000_0FFF, rdat);
    apb(0, `AGU_OFS_BREV_CTRL, 32'h0);
    chk("brev reset", 32'h0, rdat);
    apb(1, `AGU_OFS_TABLE_PAGE, 32'h0000_01A5);
    apb(0, `AGU_OFS_TABLE_PAGE, 32'h0);
    chk("table page width", 32'h0000_00A5, rdat);
    apb(0, 8'h28, 32'h0);
    chk("unmapped err", 1, rerr);
    apb(1, `AGU_OFS_STATUS, 32'hFFFF_FFFF);
    chk("status write err", 1, rerr);
    $display("done regs");
  endtask

  task automatic t_circ();
    apb(1, `AGU_OFS_X_START, 32'h0000_1000);
    apb(1, `AGU_OFS_X_END, 32'h0000_100F);
    apb(1, `AGU_OFS_Y_START, 32'h0000_2000);
    apb(1, `AGU_OFS_Y_END, 32'h0000_200F);
    apb(1, `AGU_OFS_MODE_CTRL, 32'h0000_CF32);
    setp(2, 16'h100E);
    setp(3, 16'h200D);
    dreq(AGU_X_READ, AGU_POST_INC, 0, 2, 16'h0004);
    chk("post inc ea", 32'h100E, rsp.ea);
    chk("post inc wb", 32'h1002, rsp.wb_val);
    chk("post inc wb valid", 1, rsp.wb_valid);
    chk("post inc wb sel", 2, rsp.wb_sel);
    chk("post inc wrapped", 1, rsp.wrapped);
    dreq(AGU_X_READ, AGU_PRE_DEC, 0, 2, 16'h0004);
    chk("pre dec ea", 32'h100E, rsp.ea);
    chk("pre dec wb", 32'h100E, rsp.wb_val);
    dreq(AGU_X_READ, AGU_OFFSET, 0, 2, 16'h0008);
    chk("offset ea", 32'h1006, rsp.ea);
    chk("offset no wb", 0, rsp.wb_valid);
    dreq(AGU_X_READ, AGU_POST_DEC, 0, 2, 16'h000F);
    chk("post dec ea", 32'h100E, rsp.ea);
    chk("post dec wb", 32'h100F, rsp.wb_val);
    dreq(AGU_Y_SPACE, AGU_POST_INC, 0, 3, 16'h0004);
    chk("y wb", 32'h2000, rsp.wb_val);
    $display("done circular");
  endtask

  task automatic t_brev();
    apb(1, `AGU_OFS_MODE_CTRL, 32'h0000_03FF);
    apb(1, `AGU_OFS_BREV_CTRL, 32'h0000_8008);
    // Buffer base has its low five bits clear
    setp(3, 16'h0200);
    for (int k = 0; k < 16; k++)
    begin
      dreq(AGU_X_WRITE, AGU_POST_INC, 0, 3, 16'h0002);
      chk("reversed ea", {16'h0, 16'h0200 + {11'h0, rev4(k[3:0]), 1'b0}}, rsp.ea);
      chk("reversed flag", 1, rsp.bit_reversed);
    end
    dreq(AGU_X_READ, AGU_POST_INC, 0, 3, 16'h0002);
    chk("read ea", 32'h0200, rsp.ea);
    chk("read not reversed", 0, rsp.bit_reversed);
    dreq(AGU_X_WRITE, AGU_POST_INC, 1, 3, 16'h0001);
    chk("byte wb", 32'h0203, rsp.wb_val);
    dreq(AGU_X_WRITE, AGU_INDIRECT, 0, 3, 16'h0000);
    chk("indirect not reversed", 0, rsp.bit_reversed);
    apb(1, `AGU_OFS_MODE_CTRL, 32'h0000_8333);
    setp(3, 16'h100E);
    dreq(AGU_X_READ, AGU_POST_INC, 0, 3, 16'h0002);
    chk("read keeps circular", 32'h1000, rsp.wb_val);
    dreq(AGU_X_WRITE, AGU_POST_INC, 0, 3, 16'h0002);
    chk("write reversed wb", 32'h1010, rsp.wb_val);
    dreq(AGU_X_WRITE, AGU_PRE_INC, 0, 3, 16'h0006);
    chk("pre inc reversed ea", 32'h1008, rsp.ea);
    $display("done bit reverse");
  endtask

  task automatic t_prog();
    apb(1, `AGU_OFS_TABLE_PAGE, 32'h0000_0085);
    pget(AGU_TABLE, 0, 16'h1235);
    chk("table addr", 32'h0085_1235, prsp.addr);
    chk("table config", 1, prsp.config_space);
    chk("table hit", 1, prsp.hit);
    apb(1, `AGU_OFS_TABLE_PAGE, 32'h0000_0005);
    pget(AGU_TABLE, 1, 16'h0001);
    chk("table user", 0, prsp.config_space);
    apb(1, `AGU_OFS_WINDOW_CTRL, 32'h0000_0001);
    apb(1, `AGU_OFS_VIS_PAGE, 32'h0000_0003);
    pget(AGU_WINDOW, 0, 16'h8ABC);
    chk("window addr", 32'h0001_8ABC, prsp.addr);
    chk("window low word", 1, prsp.low_word_only);
    pget(AGU_WINDOW, 1, 16'h8ABC);
    chk("window write refused", 1, prsp.refused);
    pget(AGU_WINDOW, 0, 16'h1ABC);
    chk("window miss", 0, prsp.hit);
    $display("done program space");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    give_verdict();
  end

  initial
  begin
    rst_in = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    cmd = '0;
    {ld, ld_sel, ld_val} = '0;
    preq_d = '0;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs();
    t_circ();
    t_brev();
    t_prog();
    give_verdict();
  end
endmodule // tb

`default_nettype wire
